// >>> core/usbli_top.sv
/*
  USB line state interface top: decodes received single-ended pair,
  takes differential receive data, and drives the transmit pins.
  Assumes all pin inputs synchronous to clock; clock is 12 MHz or 1.5 MHz.
*/
`timescale 1ns/10ps
`default_nettype none

module usbli_top (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire logic                  full_speed_sel,
  input  wire logic                  rx_dp_in,
  input  wire logic                  rx_dm_in,
  input  wire logic                  rx_diff_in,
  input  wire logic                  tx_active,
  input  wire logic [1:0]            tx_symbol,
  output var  usbli_pkg::usbli_line_t line_state,
  output var  logic                  line_se0,
  output var  logic                  line_undef,
  output var  logic                  rx_data,
  output var  logic                  speed_full,
  output var  logic                  tx_dp_out,
  output var  logic                  tx_dm_out,
  output var  logic                  xcvr_output_enable_n
);

  // ----------------------------------------
  // Receive line decode
  // ----------------------------------------
  usbli_pkg::usbli_line_t line_d;
  usbli_pkg::usbli_line_t line_q;
  logic                   rx_data_q;
  logic                   speed_q;

  // Registered decode; one cycle from pin to flag
  // both low is SE0
  always_comb begin
    case ({rx_dp_in, rx_dm_in})
      usbli_pkg::PAIR_SE0:  line_d = usbli_pkg::LS_SE0;
      usbli_pkg::PAIR_ZERO: line_d = usbli_pkg::LS_ZERO;
      usbli_pkg::PAIR_ONE:  line_d = usbli_pkg::LS_ONE;
      default:              line_d = usbli_pkg::LS_UNDEF;
    endcase
  end

  // reset parks an idle line
  // Idle J avoids a false SE0 flag at reset exit
  always_ff @(posedge clock) begin
    if (rst) begin
      line_q <= usbli_pkg::LS_ONE;
    end else if (clk_en) begin
      line_q <= line_d;
    end
  end

  // differential data kept apart from line state
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_data_q <= usbli_pkg::RESET_RX_DATA;
    end else if (clk_en) begin
      rx_data_q <= rx_diff_in;
    end
  end

  // speed latched; bit rate equals core clock rate
  always_ff @(posedge clock) begin
    if (rst) begin
      speed_q <= usbli_pkg::SPEED_FULL;
    end else if (clk_en) begin
      speed_q <= (full_speed_sel == usbli_pkg::SPEED_FULL);
    end
  end

  assign line_state = line_q;
  assign line_se0   = (line_q == usbli_pkg::LS_SE0);
  assign line_undef = (line_q == usbli_pkg::LS_UNDEF);
  assign rx_data    = rx_data_q;
  assign speed_full = speed_q;

  // ----------------------------------------
  // Transmit drive
  // ----------------------------------------
  // Pins and enable are registered inside, so they lag the request by one
  usbli_tx_drive u_tx (
    .clock     (clock),
    .rst       (rst),
    .clk_en    (clk_en),
    .tx_active (tx_active),
    .tx_symbol (tx_symbol),
    .dp_out    (tx_dp_out),
    .dm_out    (tx_dm_out),
    .oe_n      (xcvr_output_enable_n)
  );

  // ----------------------------------------
  // Checks: receive decode
  // ----------------------------------------
  // SE0 decode
  chk_se0_decode: assert property (@(posedge clock) disable iff (rst)
    (clk_en && !rx_dp_in && !rx_dm_in) |=> line_se0) else $error("SE0 not decoded");

  chk_zero_decode: assert property (@(posedge clock) disable iff (rst)
    (clk_en && !rx_dp_in && rx_dm_in) |=> (line_state == usbli_pkg::LS_ZERO))
    else $error("Logic 0 not decoded");

  chk_one_decode: assert property (@(posedge clock) disable iff (rst)
    (clk_en && rx_dp_in && !rx_dm_in) |=> (line_state == usbli_pkg::LS_ONE))
    else $error("Logic 1 not decoded");

  // both high flagged
  // Undefined is reported, not folded, so a stuck pair stays visible
  chk_undef_decode: assert property (@(posedge clock) disable iff (rst)
    (clk_en && rx_dp_in && rx_dm_in) |=> (line_undef && !line_se0))
    else $error("Undefined state not flagged");

  chk_se0_only: assert property (@(posedge clock) disable iff (rst)
    (clk_en && (rx_dp_in || rx_dm_in)) |=> !line_se0)
    else $error("SE0 flagged on a driven line");

  chk_rx_data_pass: assert property (@(posedge clock) disable iff (rst)
    clk_en |=> (rx_data == $past(rx_diff_in))) else $error("Receive data lost");

  chk_rx_data_hold: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(rx_data))
    else $error("Receive data moved while frozen");

  // ----------------------------------------
  // Checks: transmit drive
  // ----------------------------------------
  // logic zero driven
  chk_tx_zero_drive: assert property (@(posedge clock) disable iff (rst)
    (clk_en && tx_active && tx_symbol == usbli_pkg::PAIR_ZERO)
      |=> (!tx_dp_out && tx_dm_out))
    else $error("Logic 0 not on the pins");

  chk_tx_one_drive: assert property (@(posedge clock) disable iff (rst)
    (clk_en && tx_active && tx_symbol == usbli_pkg::PAIR_ONE)
      |=> (tx_dp_out && !tx_dm_out))
    else $error("Logic 1 not on the pins");

  chk_tx_se0_drive: assert property (@(posedge clock) disable iff (rst)
    (clk_en && tx_active && tx_symbol == usbli_pkg::PAIR_SE0)
      |=> (!tx_dp_out && !tx_dm_out))
    else $error("SE0 not on the pins");

  // undefined request folds
  // Folding to SE0 keeps the pair legal at the cost of a dropped symbol
  chk_tx_undef_fold: assert property (@(posedge clock) disable iff (rst)
    (clk_en && tx_active && tx_symbol == usbli_pkg::PAIR_UNDEF)
      |=> (!tx_dp_out && !tx_dm_out))
    else $error("Undefined request reached the pins");

  chk_tx_never_both: assert property (@(posedge clock) disable iff (rst)
    !(tx_dp_out && tx_dm_out)) else $error("Both transmit pins high");

  chk_oe_idle_high: assert property (@(posedge clock) disable iff (rst)
    (clk_en && !tx_active) |=> xcvr_output_enable_n)
    else $error("Transceiver enabled while idle");

  chk_oe_active_low: assert property (@(posedge clock) disable iff (rst)
    (clk_en && tx_active) |=> !xcvr_output_enable_n)
    else $error("Transceiver not enabled while sending");

  // pair holds when idle
  // Holding the last symbol saves a mux; the high enable hides it anyway
  chk_tx_pair_idle: assert property (@(posedge clock) disable iff (rst)
    (clk_en && !tx_active) |=> $stable({tx_dp_out, tx_dm_out}))
    else $error("Transmit pair moved while idle");

  // ----------------------------------------
  // Checks: speed, freeze and reset
  // ----------------------------------------
  // speed select follows
  chk_speed_select: assert property (@(posedge clock) disable iff (rst)
    clk_en |=> (speed_full == $past(full_speed_sel))) else $error("Speed select wrong");

  chk_speed_hold: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(speed_full)) else $error("Speed moved while frozen");

  chk_freeze_hold: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(line_state) && $stable(tx_dp_out)) else $error("State moved");

  chk_oe_hold: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(xcvr_output_enable_n))
    else $error("Enable moved while frozen");

  // reset parks idle outputs
  // No disable here: this check is about the reset itself
  chk_reset_idle: assert property (@(posedge clock)
    rst |=> (line_state == usbli_pkg::LS_ONE
      && rx_data == usbli_pkg::RESET_RX_DATA
      && {tx_dp_out, tx_dm_out} == usbli_pkg::RESET_PAIR
      && xcvr_output_enable_n == usbli_pkg::RESET_OE_N
      && speed_full == usbli_pkg::SPEED_FULL))
    else $error("Reset left outputs busy");

endmodule

`default_nettype wire

// >>> core/usbli_pkg.sv
/*
  Package for the USB line state interface: line-state codes,
  pin encodings and speed selection constants.
  Assumes a single core clock; no registers reachable by software.
*/
package usbli_pkg;

  // ----------------------------------------
  // Line states
  // ----------------------------------------
  typedef enum logic [1:0] {
    LS_SE0,
    LS_ZERO,
    LS_ONE,
    LS_UNDEF
  } usbli_line_t;

  // ----------------------------------------
  // Pin encodings {plus, minus}
  // ----------------------------------------
  localparam logic [1:0] PAIR_SE0   = 2'h0;
  localparam logic [1:0] PAIR_ZERO  = 2'h1;
  localparam logic [1:0] PAIR_ONE   = 2'h2;
  localparam logic [1:0] PAIR_UNDEF = 2'h3;

  // ----------------------------------------
  // Speed selection and core clock rates
  // ----------------------------------------
  localparam logic       SPEED_FULL    = 1'h1;
  localparam logic       SPEED_LOW     = 1'h0;
  localparam int         FULL_RATE_KHZ = 12000;
  localparam int         LOW_RATE_KHZ  = 1500;

  // Idle line after reset is logic 1 (J state at full speed)
  localparam logic [1:0] RESET_PAIR    = 2'h2;
  localparam logic       RESET_OE_N    = 1'h1;
  localparam logic       RESET_RX_DATA = 1'h1;

endpackage

// >>> core/usbli_tx_drive.sv
/*
  Transmit pin driver: registers the plus/minus output pair and the
  active-low transceiver output enable.
  Assumes the requested symbol arrives one cycle ahead of the pins.
*/
`timescale 1ns/10ps
`default_nettype none

module usbli_tx_drive (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       tx_active,
  input  wire logic [1:0] tx_symbol,
  output var  logic       dp_out,
  output var  logic       dm_out,
  output var  logic       oe_n
);

  logic [1:0] pair_d;
  logic [1:0] pair_q;

  // undefined request folds to SE0, never both high
  always_comb begin
    case (tx_symbol)
      usbli_pkg::PAIR_ZERO: pair_d = usbli_pkg::PAIR_ZERO;
      usbli_pkg::PAIR_ONE:  pair_d = usbli_pkg::PAIR_ONE;
      default:              pair_d = usbli_pkg::PAIR_SE0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pair_q <= usbli_pkg::RESET_PAIR;
    end else if (clk_en && tx_active) begin
      pair_q <= pair_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      oe_n <= usbli_pkg::RESET_OE_N;
    end else if (clk_en) begin
      oe_n <= ~tx_active;
    end
  end

  assign dp_out = pair_q[1];
  assign dm_out = pair_q[0];

  chk_pair_never_both: assert property (@(posedge clock) disable iff (rst)
    !(dp_out && dm_out)) else $error("Both output lines high");

  chk_oe_follows_req: assert property (@(posedge clock) disable iff (rst)
    clk_en |=> (oe_n == !$past(tx_active))) else $error("Output enable mismatch");

  chk_pair_encoding: assert property (@(posedge clock) disable iff (rst)
    (clk_en && tx_active && tx_symbol == usbli_pkg::PAIR_ZERO)
      |=> (!dp_out && dm_out)) else $error("Logic 0 not driven");

endmodule

`default_nettype wire

// >>> tb/usbli_xcvr_model.sv
/*
  Transceiver model for the line interface.
  Assumes the bench gives the host-side line levels.
*/
`timescale 1ns/10ps
`default_nettype none
module usbli_xcvr_model (
  input  wire logic oe_n,
  input  wire logic dp,
  input  wire logic dm,
  input  wire logic host_dp,
  input  wire logic host_dm,
  input  wire logic host_diff,
  output wire logic rx_dp,
  output wire logic rx_dm,
  output wire logic rx_diff
);
  // Receivers hear whoever owns the bus
  assign rx_dp   = oe_n ? host_dp : dp;
  assign rx_dm   = oe_n ? host_dm : dm;
  assign rx_diff = oe_n ? host_diff : dp;
endmodule
`default_nettype wire

// >>> tb/usbli_top_tb_top.sv
/*
  Bench for the line interface top.
  Assumes the transceiver model on the receive pins.
*/
`timescale 1ns/10ps
`default_nettype none
module usbli_top_tb_top;
  logic       clock = 1'h0, rst = 1'h1, clk_en = 1'h1, fs = 1'h1;
  logic       hdp = 1'h1, hdm = 1'h0, hdiff = 1'h1, tx_act = 1'h0;
  logic [1:0] sym = 2'h2;
  wire logic  rdp, rdm, rdiff, se0, und, rxd, spd, dp, dm, oen;
  usbli_pkg::usbli_line_t ls;
  int         error_cnt = 0, checks = 0;
  usbli_top dut (.clock(clock), .rst(rst), .clk_en(clk_en), .full_speed_sel(fs),
    .rx_dp_in(rdp), .rx_dm_in(rdm), .rx_diff_in(rdiff), .tx_active(tx_act),
    .tx_symbol(sym), .line_state(ls), .line_se0(se0), .line_undef(und),
    .rx_data(rxd), .speed_full(spd), .tx_dp_out(dp), .tx_dm_out(dm),
    .xcvr_output_enable_n(oen));
  usbli_xcvr_model xcvr (.oe_n(oen), .dp(dp), .dm(dm), .host_dp(hdp),
    .host_dm(hdm), .host_diff(hdiff), .rx_dp(rdp), .rx_dm(rdm), .rx_diff(rdiff));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_rx;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {hdp, hdm} <= i[1:0];
      hdiff <= i[1] ^ i[0];
      tick;
      cmp(ls, i[1:0]);
      cmp({se0, und}, {i == 0, i == 3});
      cmp(rxd, {7'h0, i[1] ^ i[0]});
    end
  endtask
  task automatic t_tx;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      tx_act <= 1'h1;
      sym <= i[1:0];
      tick;
      cmp({dp, dm, oen}, {(i == 3) ? 2'h0 : i[1:0], 1'h0});
    end
    @(posedge clock);
    tx_act <= 1'h0;
    sym <= 2'h1;
    tick;
    cmp({dp, dm, oen}, 3'h1);
  endtask
  task automatic t_speed;
    @(posedge clock);
    fs <= usbli_pkg::SPEED_LOW;
    tick;
    cmp(spd, usbli_pkg::SPEED_LOW);
    @(posedge clock);
    clk_en <= 1'h0;
    fs <= usbli_pkg::SPEED_FULL;
    tick;
    cmp(spd, usbli_pkg::SPEED_LOW);
    @(posedge clock);
    clk_en <= 1'h1;
    tick;
    cmp(spd, usbli_pkg::SPEED_FULL);
  endtask
  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  // core clock source
  initial forever #10 clock = ~clock;
  initial begin
    #20us;
    error_cnt++;
    summarize;
  end
  initial begin
    repeat (9) tick;
    cmp({ls, dp, dm, oen, rxd, spd}, {usbli_pkg::LS_ONE, 5'h17});
    @(posedge clock);
    rst <= 1'h0;
    t_rx;
    t_tx;
    t_speed;
    summarize;
  end
endmodule
`default_nettype wire
